/* fcoc_chk.sv */
// assertion checker for the flash clock and option control block
`default_nettype none
module fcoc_chk (
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // control side
  input wire logic [7:0] option_stored_byte,
  input wire logic       key_wr,
  input wire logic       key_wr_secure_src,
  input wire logic       blank_check_erased,
  input wire logic       mem_req,
  input wire logic       mem_req_secure_src,
  input wire logic       pe_request,
  input wire logic       timing_pulse,
  input wire logic       pe_enable,
  input wire logic       pe_start,
  input wire logic       mem_access_allowed,
  input wire logic       array_read_invalid,
  input wire logic       key_write_taken,
  input wire logic       redirect_enable,
  input wire logic       secure
);
  // -----------------------------------------
  // option copy seen at first edge after reset
  // -----------------------------------------
  logic [1:0] up_cnt_reg;
  logic [7:0] opt_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) up_cnt_reg <= 2'h0;
    else if (up_cnt_reg != 2'h3) up_cnt_reg <= up_cnt_reg + 2'h1;
    if (aresetn && up_cnt_reg == 2'h0) opt_reg <= option_stored_byte;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_pe_gate: assert property (pe_start |-> pe_request && pe_enable && !array_read_invalid)
    else $error("erase or program started while blocked");
  chk_pe_open: assert property (pe_request && pe_enable && !array_read_invalid |-> pe_start)
    else $error("erase or program held off after divider load");
  chk_loaded_hold: assert property (pe_enable |=> pe_enable)
    else $error("loaded flag dropped without reset");
  chk_pulse_gate: assert property (!pe_enable |-> !timing_pulse)
    else $error("timing strobe before divider load");
  chk_mem_block: assert property (mem_req && secure && !mem_req_secure_src |-> !mem_access_allowed)
    else $error("unsecured access let through while secure");
  chk_key_src: assert property (key_write_taken |-> key_wr && key_wr_secure_src && array_read_invalid)
    else $error("key byte taken from wrong source");
  chk_redirect_bit: assert property (up_cnt_reg == 2'h3 |-> redirect_enable == !opt_reg[6])
    else $error("redirect enable does not follow option");
  chk_key_lock: assert property (up_cnt_reg == 2'h3 && $fell(secure) && !opt_reg[7]
    |-> $past(blank_check_erased) || $past(blank_check_erased, 2))
    else $error("security dropped with key disabled");
  cov_pulse: cover property (timing_pulse);
  cov_unsecure: cover property ($fell(secure));
  cov_start: cover property (pe_start);
endmodule
bind fcoc_top fcoc_chk fcoc_chk_inst (.aclk, .aresetn, .option_stored_byte, .key_wr, .key_wr_secure_src,
  .blank_check_erased, .mem_req, .mem_req_secure_src, .pe_request, .timing_pulse, .pe_enable, .pe_start,
  .mem_access_allowed, .array_read_invalid, .key_write_taken, .redirect_enable, .secure);
`default_nettype wire

/* fcoc_consts.vh */
// constants for the flash clock and option control block
//
// Overview of operation
// (R1) Loaded flag clears on reset, sets on first divider write regardless of data.
// (R2) Divider bits 6..0 always readable, accept only the first write after reset.
// (R3) Erase and program are blocked until the loaded flag is set.
// (R4) Software writes the divider before any erase or program attempt.
// (R5) Prescale bit set feeds the divider with bus clock over eight, else bus clock.
// (R6) Prescaled clock is divided by divider value plus one.
// (R7) Software keeps the timing clock between 150 kHz and 200 kHz.
// (R8) One timing pulse lasts one timing clock period; operations count whole pulses.
// (R9) Stored option byte is copied into the working option register during reset; code copies it on the first clock after reset release.
// (R10) Working option bits 5..2 always read zero.
// (R11) Working option register is read-only; changes only on a new reset; code also sets bits 1..0 to 10 on key match or erased blank check.
// (R12) Backdoor key disabled never disengages security.
// (R13) With key enabled, matching eight ordered key bytes unsecure until next reset.
// (R14) Key bytes accepted only from secured user firmware, never from debug path.
// (R15) Redirect disable bit one disables vector redirection, zero enables it.
// (R16) Security code 10 means unsecured; 00, 01 and 11 mean secure.
// (R17) While secure, memory access from unsecured sources is blocked.
// (R18) Security code becomes 10 after key match or erased-array blank check.
// (R19) Configuration bits 7..5 read/write; bits 4..0 read zero, ignore writes.
// (R20) Key access set turns key writes into compare bytes; array reads invalid.
// (R21) Clearing key access compares written bytes with stored key; match unsecures.
// (R22) Timing clock is a one-cycle enable strobe from a reloading counter.
`ifndef FCOC_CONSTS_VH
`define FCOC_CONSTS_VH

// register byte offsets
`define FCOC_OFF_DIV       4'h0
`define FCOC_OFF_OPT       4'h4
`define FCOC_OFF_CNFG      4'h8
`define FCOC_OFF_STAT      4'hC

// divider fields
`define FCOC_DIV_LOADED    7
`define FCOC_DIV_PRESCALE  6

// option fields
`define FCOC_OPT_BACKDOOR_KEY_ENABLE     7
`define FCOC_OPT_NORED     6
`define FCOC_OPT_MASK      8'hC3

// configuration fields
`define FCOC_CNFG_KEY_ACCESS_ENABLE   5
`define FCOC_CNFG_MASK     8'hE0

// security codes
`define FCOC_SEC_UNSECURE  2'h2

// reset values
`define FCOC_DIV_RST       8'h00
`define FCOC_CNFG_RST      8'h00

// prescaler and key byte count
`define FCOC_PRESCALE_DIV  3'h7
`define FCOC_KEY_BYTES     4'h8

// axi responses
`define FCOC_RESP_OKAY     2'h0
`define FCOC_RESP_SLVERR   2'h2

`endif

/* fcoc_top.v */
// flash clock divider, option byte and security control
`default_nettype none
`include "fcoc_consts.vh"

module fcoc_top (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // nonvolatile option and key contents
  input  wire [7:0]  option_stored_byte,
  input  wire [63:0] stored_backdoor_key,
  // key location writes from the memory bus
  input  wire        key_wr,
  input  wire [7:0]  key_wr_data,
  input  wire        key_wr_secure_src,
  // blank check result from the sequencer
  input  wire        blank_check_erased,
  // memory access requests
  input  wire        mem_req,
  input  wire        mem_req_secure_src,
  // sequencer request for an erase or program operation
  input  wire        pe_request,
  // outputs to memory and sequencer
  output wire        timing_pulse,
  output wire        pe_enable,
  output wire        pe_start,
  output wire        mem_access_allowed,
  output wire        array_read_invalid,
  output wire        key_write_taken,
  output wire        redirect_enable,
  output wire        secure
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg  [7:0]  div_reg;
  reg  [7:0]  opt_reg;
  reg  [7:0]  cnfg_reg;
  reg         opt_loaded_reg;
  reg  [63:0] key_buf_reg;
  reg  [3:0]  key_cnt_reg;
  reg  [2:0]  pre_cnt_reg;
  reg  [5:0]  div_cnt_reg;
  reg         pulse_reg;
  reg         bvalid_reg;
  reg  [1:0]  bresp_reg;
  reg         rvalid_reg;
  reg  [31:0] rdata_reg;
  reg  [1:0]  rresp_reg;
  reg         aw_held_reg;
  reg  [3:0]  aw_addr_reg;
  reg         w_held_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;

  wire        divisor_loaded_flag = div_reg[`FCOC_DIV_LOADED];
  wire        prescale_by_eight   = div_reg[`FCOC_DIV_PRESCALE];
  wire [5:0]  divider_value       = div_reg[5:0];
  wire        backdoor_key_enable = opt_reg[`FCOC_OPT_BACKDOOR_KEY_ENABLE];
  wire        key_access_enable   = cnfg_reg[`FCOC_CNFG_KEY_ACCESS_ENABLE];
  wire [1:0]  security_state_code = opt_reg[1:0];

  // ------------------------------------------------------------
  // axi4-lite write path
  // ------------------------------------------------------------
  // address and data may arrive in either order; each is held until both exist
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;

  wire        aw_fire = s_axi_awvalid && s_axi_awready;
  wire        w_fire  = s_axi_wvalid && s_axi_wready;
  wire        aw_have = aw_held_reg || aw_fire;
  wire        w_have  = w_held_reg || w_fire;
  wire        wr_do   = aw_have && w_have && !bvalid_reg;
  wire [3:0]  wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
  wire [31:0] wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
  wire [3:0]  wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
  wire        wr_lane = wr_strb[0];
  wire        wr_div  = wr_do && wr_lane && (wr_addr == `FCOC_OFF_DIV);
  wire        wr_cnfg = wr_do && wr_lane && (wr_addr == `FCOC_OFF_CNFG);
  wire        wr_map  = (wr_addr == `FCOC_OFF_DIV) || (wr_addr == `FCOC_OFF_OPT) ||
                        (wr_addr == `FCOC_OFF_CNFG) || (wr_addr == `FCOC_OFF_STAT);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_held_reg  <= 1'b0;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `FCOC_RESP_OKAY;
    end else begin
      if (wr_do) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_map ? `FCOC_RESP_OKAY : `FCOC_RESP_SLVERR;
      end else begin
        if (aw_fire) begin
          aw_held_reg <= 1'b1;
          aw_addr_reg <= s_axi_awaddr;
        end
        if (w_fire) begin
          w_held_reg <= 1'b1;
          w_data_reg <= s_axi_wdata;
          w_strb_reg <= s_axi_wstrb;
        end
        if (bvalid_reg && s_axi_bready)
          bvalid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  // ------------------------------------------------------------
  // divider and configuration registers
  // ------------------------------------------------------------
  wire key_close = wr_cnfg && key_access_enable && !wr_data[`FCOC_CNFG_KEY_ACCESS_ENABLE];

  always @(posedge aclk) begin
    if (!aresetn) begin
      div_reg  <= `FCOC_DIV_RST; // R1
      cnfg_reg <= `FCOC_CNFG_RST;
    end else begin
      if (wr_div && !divisor_loaded_flag)
        div_reg <= {1'b1, wr_data[6:0]}; // R1 R2
      if (wr_cnfg)
        cnfg_reg <= wr_data[7:0] & `FCOC_CNFG_MASK; // R19
    end
  end

  // ------------------------------------------------------------
  // option register and security
  // ------------------------------------------------------------
  // the option byte is captured on the first clock after reset release
  // since a synchronous reset may only load constants
  wire key_match = (key_cnt_reg == `FCOC_KEY_BYTES) && (key_buf_reg == stored_backdoor_key);

  always @(posedge aclk) begin
    if (!aresetn) begin
      opt_loaded_reg <= 1'b0;
      opt_reg        <= 8'h00;
    end else if (!opt_loaded_reg) begin
      opt_loaded_reg <= 1'b1;
      opt_reg        <= option_stored_byte & `FCOC_OPT_MASK; // R9 R10 R11
    end else if ((key_close && backdoor_key_enable && key_match) || blank_check_erased) begin
      opt_reg[1:0] <= `FCOC_SEC_UNSECURE; // R12 R13 R18 R21
    end
  end

  // key bytes collected in order, first byte in the top byte of the buffer
  wire key_accept = key_wr && key_access_enable && key_wr_secure_src; // R14 R20

  always @(posedge aclk) begin
    if (!aresetn) begin
      key_buf_reg <= 64'h0000000000000000;
      key_cnt_reg <= 4'h0;
    end else if (key_close || (wr_cnfg && wr_data[`FCOC_CNFG_KEY_ACCESS_ENABLE] && !key_access_enable)) begin
      key_cnt_reg <= 4'h0;
    end else if (key_accept && (key_cnt_reg != `FCOC_KEY_BYTES)) begin
      key_buf_reg <= {key_buf_reg[55:0], key_wr_data}; // R13
      key_cnt_reg <= key_cnt_reg + 4'h1;
    end
  end

  assign secure             = (security_state_code != `FCOC_SEC_UNSECURE) || !opt_loaded_reg; // R16
  assign mem_access_allowed = mem_req && (!secure || mem_req_secure_src); // R17
  assign array_read_invalid = key_access_enable; // R20
  assign key_write_taken    = key_accept;
  assign redirect_enable    = !opt_reg[`FCOC_OPT_NORED]; // R15

  // ------------------------------------------------------------
  // timing clock strobe
  // ------------------------------------------------------------
  // an enable strobe instead of a gated clock keeps one clock domain
  wire pre_tick = !prescale_by_eight || (pre_cnt_reg == `FCOC_PRESCALE_DIV); // R5
  wire div_end  = (div_cnt_reg == divider_value);

  always @(posedge aclk) begin
    if (!aresetn || !divisor_loaded_flag) begin
      pre_cnt_reg <= 3'h0;
      div_cnt_reg <= 6'h00;
      pulse_reg   <= 1'b0;
    end else begin
      pre_cnt_reg <= pre_tick ? 3'h0 : pre_cnt_reg + 3'h1; // R5
      pulse_reg   <= pre_tick && div_end; // R8 R22
      if (pre_tick)
        div_cnt_reg <= div_end ? 6'h00 : div_cnt_reg + 6'h01; // R6 R22
    end
  end

  assign timing_pulse = pulse_reg; // R8
  assign pe_enable    = divisor_loaded_flag; // R3
  assign pe_start     = pe_request && divisor_loaded_flag && !key_access_enable; // R3 R20

  // ------------------------------------------------------------
  // axi4-lite read path
  // ------------------------------------------------------------
  assign s_axi_arready = !rvalid_reg;

  reg [7:0] rd_byte;
  reg       rd_ok;
  always @* begin
    rd_byte = 8'h00;
    rd_ok   = 1'b1;
    case (s_axi_araddr)
      `FCOC_OFF_DIV:  rd_byte = div_reg;
      `FCOC_OFF_OPT:  rd_byte = opt_reg;
      `FCOC_OFF_CNFG: rd_byte = cnfg_reg;
      `FCOC_OFF_STAT: rd_byte = {4'h0, key_cnt_reg};
      default:        rd_ok   = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= `FCOC_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= {24'h000000, rd_byte};
      rresp_reg  <= rd_ok ? `FCOC_RESP_OKAY : `FCOC_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

endmodule
`default_nettype wire

/* tb.sv */
// self-checking bench for the flash clock and option control block
`default_nettype none
`include "fcoc_consts.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, key_wr, key_wr_secure_src;
  logic        blank_check_erased, mem_req, mem_req_secure_src, pe_request, timing_pulse, pe_enable, pe_start;
  logic        mem_access_allowed, array_read_invalid, key_write_taken, redirect_enable, secure, pd;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [5:0]  dv;
  logic [7:0]  option_stored_byte, key_wr_data, m_div;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_val;
  logic [63:0] stored_backdoor_key;
  int          err_count, checks, seed, n, k, run, i;
  fcoc_top fcoc_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .option_stored_byte, .stored_backdoor_key, .key_wr, .key_wr_data, .key_wr_secure_src, .blank_check_erased,
    .mem_req, .mem_req_secure_src, .pe_request, .timing_pulse, .pe_enable, .pe_start, .mem_access_allowed,
    .array_read_invalid, .key_write_taken, .redirect_enable, .secure);
  initial begin
    aclk = 0;
    forever #50 aclk = ~aclk;
  end
  // ---------------------------
  // bus and key tasks
  // ---------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // every polling wait goes through here so a hang is cut short
  task automatic stall;
    n++;
    if (n > 150) begin
      err_count++;
      close_out;
    end
    @(posedge aclk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 0; w = 0; n = 0;
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    do begin
      stall;
      if (s_axi_awready) begin aw = 1; s_axi_awvalid <= 0; end
      if (s_axi_wready) begin w = 1; s_axi_wvalid <= 0; end
    end while (!(aw && w));
    do stall; while (!s_axi_bvalid);
  endtask
  task automatic rd(input logic [3:0] a);
    n = 0; s_axi_araddr <= a; s_axi_arvalid <= 1;
    do stall; while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do stall; while (!s_axi_rvalid);
    rd_val = s_axi_rdata;
  endtask
  // key bytes never on adjacent cycles
  task automatic key(input logic [7:0] b, input logic src);
    n = 0; key_wr <= 1; key_wr_data <= b; key_wr_secure_src <= src;
    stall;
    `CHK(key_write_taken, src)
    key_wr <= 0;
    stall;
  endtask
  initial begin
    seed = 32'h58BF;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, key_wr, blank_check_erased, key_wr_secure_src} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, key_wr_data, option_stored_byte, stored_backdoor_key} = 0;
    // unsecured-source memory request and an erase request stand throughout
    {mem_req_secure_src, mem_req, pe_request, s_axi_bready, s_axi_rready, s_axi_wstrb} = 9'h0FF;
    err_count = 0; checks = 0;
    for (run = 0; run < 2; run++) begin
      aresetn <= 0;
      option_stored_byte <= (run ? 8'h81 : 8'h43) | (8'($random(seed)) & 8'h3C);
      stored_backdoor_key <= {$random(seed), $random(seed)};
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      repeat (3) @(posedge aclk);
      `CHK(secure, 1'b1)
      `CHK(redirect_enable, !option_stored_byte[6])
      `CHK({pe_enable, pe_start, mem_access_allowed}, 3'h0)
      rd(`FCOC_OFF_OPT); `CHK(rd_val, {24'h0, option_stored_byte & 8'hC3})
      wr(`FCOC_OFF_OPT, 32'hFF); rd(`FCOC_OFF_OPT); `CHK(rd_val, {24'h0, option_stored_byte & 8'hC3})
      rd(`FCOC_OFF_DIV); `CHK(rd_val, 32'h0)
      pd = (run == 0);
      // settings keep the timing clock inside its band at a 10 MHz bus clock
      dv = pd ? 6'(6 + ($random(seed) & 1)) : 6'(49 + ($random(seed) & 7));
      m_div = {1'b0, pd, dv};
      // divider is loaded before any erase or program is expected to start
      wr(`FCOC_OFF_DIV, {24'hFFFFFF, run[0], pd, dv});
      rd(`FCOC_OFF_DIV); `CHK(rd_val, {24'h0, 8'h80 | m_div})
      `CHK({pe_enable, pe_start}, 2'h3)
      wr(`FCOC_OFF_DIV, {24'h0, 8'h3F ^ m_div}); rd(`FCOC_OFF_DIV); `CHK(rd_val, {24'h0, 8'h80 | m_div})
      n = 0;
      do stall; while (!timing_pulse);
      k = 0; n = 0;
      do begin stall; k++; end while (!timing_pulse);
      `CHK(k, (pd ? 8 : 1) * (dv + 1))
      wr(`FCOC_OFF_CNFG, 32'hFF); rd(`FCOC_OFF_CNFG); `CHK(rd_val, 32'hE0)
      `CHK(array_read_invalid, 1'b1)
      key(stored_backdoor_key[63:56], 1'b0);
      for (i = 0; i < 8; i++) key(stored_backdoor_key[63 - 8 * i -: 8], 1'b1);
      wr(`FCOC_OFF_CNFG, 32'h0);
      `CHK(secure, run == 0)
      `CHK(mem_access_allowed, run != 0)
      blank_check_erased <= 1;
      @(posedge aclk);
      blank_check_erased <= 0;
      repeat (2) @(posedge aclk);
      `CHK(secure, 1'b0)
      $display("run %0d done", run);
    end
    close_out;
  end
endmodule
`default_nettype wire
